// ---- rtl/dbt_cfg.svh ----
// Purpose: shared offsets, bit positions and reset values of the debug block
// Assumes: included by bare name from every design file that needs it
// Notes: register indices are byte offsets in the local debug window
`ifndef DBT_CFG_SVH
`define DBT_CFG_SVH

// ----------------------------------------------------------------
// register indices in the cpu memory window
// ----------------------------------------------------------------
`define DBT_IDX_CAH 4'h0
`define DBT_IDX_CAL 4'h1
`define DBT_IDX_CBH 4'h2
`define DBT_IDX_CBL 4'h3
`define DBT_IDX_FH 4'h4
`define DBT_IDX_FL 4'h5
`define DBT_IDX_CTRL 4'h6
`define DBT_IDX_TRIG 4'h7
`define DBT_IDX_STAT 4'h8
`define DBT_IDX_FRC 4'h9

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define DBT_CTRL_EN 7
`define DBT_CTRL_ARM 6
`define DBT_CTRL_TAG 5
`define DBT_CTRL_BRK 4
`define DBT_CTRL_RW_MSB 3
`define DBT_STAT_TRACE_RUNNING_FLAG 7
`define DBT_FRC_BIT 0
`define DBT_BYTE_ZERO 8'h00
`define DBT_WORD_ZERO 16'h0000
`define DBT_RW_RST 4'h0

`endif

// ---- rtl/dbt_pkg.sv ----
// Purpose: types shared by the debug breakpoint and trace block
// Assumes: nothing beyond the cfg header
// Notes: serial commands arrive one-hot from the serial front end
package dbt_pkg;

   // ----------------------------------------------------------------
   // serial background command codes
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      SC_WRITE_BREAKPOINT_CMD = 3'h1,
      SC_READ_BREAKPOINT_CMD = 3'h2,
      SC_WRITE_BYTE = 3'h4
   } dbt_sercmd_type;

   typedef logic [15:0] dbt_word_type;

endpackage : dbt_pkg

// ---- rtl/dbt_fifo_if.sv ----
// Purpose: carries the shift request, new word and head word of the trace fifo
// Assumes: single clock domain, driven by the register logic
// Notes: no clocking block; plain wires between two design modules
`timescale 1ns/1ps
interface dbt_fifo_if;
   logic shift;
   dbt_pkg::dbt_word_type din;
   dbt_pkg::dbt_word_type head;

   modport ctrl (output shift, output din, input head);
   modport store (input shift, input din, output head);
endinterface : dbt_fifo_if

// ---- rtl/dbt_cmp_reg.sv ----
// Purpose: one 16-bit comparator value register with byte writes and address match
// Assumes: wr_hi and wr_lo are one-cycle strobes from the cpu decode
// Notes: match is registered so it lines up with other trace flags
`timescale 1ns/1ps
`include "dbt_cfg.svh"
module dbt_cmp_reg #(
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic lock,
   input wire logic wr_hi,
   input wire logic wr_lo,
   input wire logic [7:0] wdata,
   input wire logic [W-1:0] bus_addr,
   input wire logic bus_valid,
   output logic [W-1:0] value,
   output logic match
);
   logic [W-1:0] value_r;
   logic match_r;

   // the byte split only makes sense for exactly two bytes
   if (W != 16) begin : g_chk
      $error("dbt_cmp_reg supports only W = 16");
   end

   // ----------------------------------------------------------------
   // value register; writes are dropped while the run is armed
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         value_r <= `DBT_WORD_ZERO;
         match_r <= 1'b0;
      end else if (ce) begin
         if (wr_hi && !lock) begin
            value_r[W-1:8] <= wdata;
         end
         if (wr_lo && !lock) begin
            value_r[7:0] <= wdata;
         end
         match_r <= bus_valid && (bus_addr == value_r);
      end
   end

   assign value = value_r;
   assign match = match_r;
endmodule : dbt_cmp_reg

// ---- rtl/dbt_trace_fifo.sv ----
// Purpose: trace fifo storage as a shift chain, head at entry 0
// Assumes: one shift per cycle at most
// Notes: new words enter at the last entry; a shift drops the head
`timescale 1ns/1ps
`include "dbt_cfg.svh"
module dbt_trace_fifo #(
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   dbt_fifo_if.store f
);
   dbt_pkg::dbt_word_type store_r [DEPTH];

   if (DEPTH < 2) begin : g_chk
      $error("dbt_trace_fifo needs DEPTH of at least 2");
   end

   // ----------------------------------------------------------------
   // shift chain; a chain costs muxes but needs no pointers
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         for (int i = 0; i < DEPTH; i++) begin
            store_r[i] <= `DBT_WORD_ZERO;
         end
      end else if (ce && f.shift) begin
         for (int i = 0; i < DEPTH - 1; i++) begin
            store_r[i] <= store_r[i+1];
         end
         store_r[DEPTH-1] <= f.din;
      end
   end

   assign f.head = store_r[0];
endmodule : dbt_trace_fifo

// ---- rtl/dbt_debug_regs.sv ----
// Purpose: breakpoint, forced reset and trace register logic of the debug block
// Assumes: cpu and serial strobes are one-cycle and synchronous to CLK_SYS
// Notes: trigger modes and the trigger register are outside this block
//
// Behaviour
// - hold 16-bit breakpoint address, reached only by serial breakpoint commands
// - breakpoint enable and force/tag select steer breakpoint matching
// - breakpoint enable clear means no breakpoint at all
// - force select requests background; tag select tags the matching fetch
// - forced-reset writes accepted only from serial write-byte command
// - cpu writes to forced-reset ignored; reads return zero
// - serial one into bit 0 of forced-reset issues chip reset
// - trace registers live in the cpu memory window
// - comparator A value split into high and low byte registers
// - comparator B value split into high and low byte registers
// - comparator bytes reset to zero, always readable, locked while armed
// - fifo high byte is read only, shows upper half of head
// - fifo low byte is read only, shows lower half of head
// - event-only captures store the low byte, high byte zero
// - reading fifo high byte never advances the fifo
// - each fifo low byte read advances to next word
// - low byte reads do not advance while armed
// - unarmed low byte read pushes last fetched opcode address
// - fifo holds eight words; ninth read returns first read capture
// - trace control readable and writable at any time
// - control bit 7 enables trace; setting blocked while secured
// - armed clears on run completion or writing zero to arm or enable
`timescale 1ns/1ps
`include "dbt_cfg.svh"
module dbt_debug_regs #(
   parameter int FIFO_DEPTH = 8
) (
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic CE,
   // cpu memory window
   input wire logic [3:0] CPU_ADDR,
   input wire logic CPU_RD,
   input wire logic CPU_WR,
   input wire logic [7:0] CPU_WDATA,
   output logic [7:0] CPU_RDATA,
   // cpu address bus observation
   input wire logic [15:0] CPU_BUS_ADDR,
   input wire logic CPU_BUS_VALID,
   input wire logic OPCODE_FETCH,
   input wire logic SECURED,
   input wire logic RUN_DONE,
   // capture from trigger logic
   input wire logic TRACE_CAP_VALID,
   input wire logic [15:0] TRACE_CAP_DATA,
   input wire logic EVENT_ONLY,
   // serial debug status/control bits
   input wire logic BKPT_ENABLE,
   input wire logic FORCE_TAG_SELECT,
   // serial background commands
   input wire logic SER_CMD_VALID,
   input wire logic [2:0] SER_CMD,
   input wire logic [3:0] SER_ADDR,
   input wire logic [15:0] SER_WDATA,
   output logic [15:0] SER_RDATA,
   output logic SER_RVALID,
   // requests and status to the core
   output logic BKPT_FORCE_REQ,
   output logic BKPT_TAG,
   output logic MCU_RESET_REQ,
   output logic CMP_A_MATCH,
   output logic CMP_B_MATCH,
   output logic TRACE_ENABLE,
   output logic TRACE_ARMED,
   output logic TRACE_TAG_MODE,
   output logic TRACE_BREAK_EN,
   output logic [3:0] TRACE_RW_SEL
);

   if (FIFO_DEPTH != 8) begin : g_chk
      $error("dbt_debug_regs: profiling sequence is built for FIFO_DEPTH = 8");
   end

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   logic [15:0] bkpt_r;
   logic en_r;
   logic en_nxt;
   logic armed_r;
   logic armed_nxt;
   logic tag_r;
   logic brk_r;
   logic [3:0] rw_r;
   logic [15:0] last_fetch_r;
   logic [7:0] rdata_r;
   logic [15:0] ser_rdata_r;
   logic ser_rvalid_r;
   logic force_req_r;
   logic bkpt_tag_r;
   logic reset_req_r;

   dbt_fifo_if fifo_bus ();

   // ----------------------------------------------------------------
   // cpu decode
   // ----------------------------------------------------------------
   logic wr_cah;
   logic wr_cal;
   logic wr_cbh;
   logic wr_cbl;
   logic wr_ctrl;
   logic rd_fl;
   logic [15:0] cmp_a_val;
   logic [15:0] cmp_b_val;

   // the cpu window has no decode for the breakpoint word at all
   // trace regs cpu mapped
   assign wr_cah = CPU_WR && (CPU_ADDR == `DBT_IDX_CAH);
   assign wr_cal = CPU_WR && (CPU_ADDR == `DBT_IDX_CAL);
   assign wr_cbh = CPU_WR && (CPU_ADDR == `DBT_IDX_CBH);
   assign wr_cbl = CPU_WR && (CPU_ADDR == `DBT_IDX_CBL);
   assign wr_ctrl = CPU_WR && (CPU_ADDR == `DBT_IDX_CTRL);
   assign rd_fl = CPU_RD && (CPU_ADDR == `DBT_IDX_FL);

   // ----------------------------------------------------------------
   // serial decode
   // ----------------------------------------------------------------
   logic ser_wr_bkpt;
   logic ser_rd_bkpt;
   logic ser_wr_frc;

   assign ser_wr_bkpt = SER_CMD_VALID && (SER_CMD == dbt_pkg::SC_WRITE_BREAKPOINT_CMD);
   assign ser_rd_bkpt = SER_CMD_VALID && (SER_CMD == dbt_pkg::SC_READ_BREAKPOINT_CMD);
   assign ser_wr_frc = SER_CMD_VALID && (SER_CMD == dbt_pkg::SC_WRITE_BYTE)
                       && (SER_ADDR == `DBT_IDX_FRC);

   // ----------------------------------------------------------------
   // control next values
   // ----------------------------------------------------------------
   // enable set blocked when secured
   assign en_nxt = wr_ctrl ? (CPU_WDATA[`DBT_CTRL_EN] && !SECURED) : en_r;
   // arm cleared by write or run end
   assign armed_nxt = wr_ctrl ? (CPU_WDATA[`DBT_CTRL_ARM] && en_nxt)
                    : (RUN_DONE ? 1'b0 : armed_r);

   // ----------------------------------------------------------------
   // trace fifo feed
   // ----------------------------------------------------------------
   logic [15:0] cap_word;

   assign cap_word = EVENT_ONLY ? {`DBT_BYTE_ZERO, TRACE_CAP_DATA[7:0]} : TRACE_CAP_DATA;
   assign fifo_bus.shift = (armed_r && TRACE_CAP_VALID) || (rd_fl && !armed_r);
   assign fifo_bus.din = armed_r ? cap_word : last_fetch_r;

   // ----------------------------------------------------------------
   // cpu read mux
   // ----------------------------------------------------------------
   logic [7:0] rd_mux;
   logic [7:0] ctrl_byte;
   logic [7:0] stat_byte;

   assign ctrl_byte = {en_r, armed_r, tag_r, brk_r, rw_r};
   assign stat_byte = {armed_r, 7'h00};
   // both bytes from one head word
   assign rd_mux = (CPU_ADDR == `DBT_IDX_CAH) ? cmp_a_val[15:8]
                 : (CPU_ADDR == `DBT_IDX_CAL) ? cmp_a_val[7:0]
                 : (CPU_ADDR == `DBT_IDX_CBH) ? cmp_b_val[15:8]
                 : (CPU_ADDR == `DBT_IDX_CBL) ? cmp_b_val[7:0]
                 : (CPU_ADDR == `DBT_IDX_FH) ? fifo_bus.head[15:8]
                 : (CPU_ADDR == `DBT_IDX_FL) ? fifo_bus.head[7:0]
                 : (CPU_ADDR == `DBT_IDX_CTRL) ? ctrl_byte
                 : (CPU_ADDR == `DBT_IDX_STAT) ? stat_byte
                 : `DBT_BYTE_ZERO;

   // ----------------------------------------------------------------
   // breakpoint match
   // ----------------------------------------------------------------
   logic bkpt_hit;

   assign bkpt_hit = BKPT_ENABLE && CPU_BUS_VALID && (CPU_BUS_ADDR == bkpt_r);

   // ----------------------------------------------------------------
   // trace control register and armed flag
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         en_r <= 1'b0;
         armed_r <= 1'b0;
         tag_r <= 1'b0;
         brk_r <= 1'b0;
         rw_r <= `DBT_RW_RST;
      end else if (CE) begin
         en_r <= en_nxt;
         armed_r <= armed_nxt;
         if (wr_ctrl) begin
            tag_r <= CPU_WDATA[`DBT_CTRL_TAG];
            brk_r <= CPU_WDATA[`DBT_CTRL_BRK];
            rw_r <= CPU_WDATA[`DBT_CTRL_RW_MSB:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // breakpoint word, serial access only
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         bkpt_r <= `DBT_WORD_ZERO;
         ser_rdata_r <= `DBT_WORD_ZERO;
         ser_rvalid_r <= 1'b0;
      end else if (CE) begin
         if (ser_wr_bkpt) begin
            bkpt_r <= SER_WDATA;
         end
         if (ser_rd_bkpt) begin
            ser_rdata_r <= bkpt_r;
         end
         ser_rvalid_r <= ser_rd_bkpt;
      end
   end

   // ----------------------------------------------------------------
   // break requests and forced reset
   // ----------------------------------------------------------------
   // a tag only marks the fetch; the core decides whether it executes
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         force_req_r <= 1'b0;
         bkpt_tag_r <= 1'b0;
         reset_req_r <= 1'b0;
      end else if (CE) begin
         force_req_r <= bkpt_hit && FORCE_TAG_SELECT;
         bkpt_tag_r <= bkpt_hit && !FORCE_TAG_SELECT && OPCODE_FETCH;
         // one in bit 0 resets chip
         reset_req_r <= ser_wr_frc && SER_WDATA[`DBT_FRC_BIT];
      end
   end

   // ----------------------------------------------------------------
   // last fetch address and cpu read data
   // ----------------------------------------------------------------
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         last_fetch_r <= `DBT_WORD_ZERO;
         rdata_r <= `DBT_BYTE_ZERO;
      end else if (CE) begin
         if (CPU_BUS_VALID && OPCODE_FETCH) begin
            last_fetch_r <= CPU_BUS_ADDR;
         end
         if (CPU_RD) begin
            rdata_r <= rd_mux;
         end
      end
   end

   // ----------------------------------------------------------------
   // comparators
   // ----------------------------------------------------------------
   // comparator A bytes
   dbt_cmp_reg #(.W(16)) u_cmp_a (
      .clk(CLK_SYS),
      .rst(RST),
      .ce(CE),
      .lock(armed_r),
      .wr_hi(wr_cah),
      .wr_lo(wr_cal),
      .wdata(CPU_WDATA),
      .bus_addr(CPU_BUS_ADDR),
      .bus_valid(CPU_BUS_VALID),
      .value(cmp_a_val),
      .match(CMP_A_MATCH)
   );

   dbt_cmp_reg #(.W(16)) u_cmp_b (
      .clk(CLK_SYS),
      .rst(RST),
      .ce(CE),
      .lock(armed_r),
      .wr_hi(wr_cbh),
      .wr_lo(wr_cbl),
      .wdata(CPU_WDATA),
      .bus_addr(CPU_BUS_ADDR),
      .bus_valid(CPU_BUS_VALID),
      .value(cmp_b_val),
      .match(CMP_B_MATCH)
   );

   // ----------------------------------------------------------------
   // trace fifo
   // ----------------------------------------------------------------
   // eight deep profile chain
   dbt_trace_fifo #(.DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(CLK_SYS),
      .rst(RST),
      .ce(CE),
      .f(fifo_bus.store)
   );

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign CPU_RDATA = rdata_r;
   assign SER_RDATA = ser_rdata_r;
   assign SER_RVALID = ser_rvalid_r;
   assign BKPT_FORCE_REQ = force_req_r;
   assign BKPT_TAG = bkpt_tag_r;
   assign MCU_RESET_REQ = reset_req_r;
   assign TRACE_ENABLE = en_r;
   assign TRACE_ARMED = armed_r;
   assign TRACE_TAG_MODE = tag_r;
   assign TRACE_BREAK_EN = brk_r;
   assign TRACE_RW_SEL = rw_r;
endmodule : dbt_debug_regs

// ---- dv/dbt_debug_regs_sva.sv ----
// Purpose: port-level checks of the debug breakpoint and trace registers
// Assumes: one clock domain, synchronous reset
// Notes: bound to every instance of dbt_debug_regs
`timescale 1ns/1ps
`include "dbt_cfg.svh"
module dbt_debug_regs_sva (
   input wire logic CLK_SYS,
   input wire logic RST,
   input wire logic CE,
   input wire logic [3:0] CPU_ADDR,
   input wire logic CPU_RD,
   input wire logic CPU_WR,
   input wire logic [7:0] CPU_WDATA,
   input wire logic [7:0] CPU_RDATA,
   input wire logic CPU_BUS_VALID,
   input wire logic OPCODE_FETCH,
   input wire logic SECURED,
   input wire logic RUN_DONE,
   input wire logic BKPT_ENABLE,
   input wire logic FORCE_TAG_SELECT,
   input wire logic SER_CMD_VALID,
   input wire logic [2:0] SER_CMD,
   input wire logic [3:0] SER_ADDR,
   input wire logic [15:0] SER_WDATA,
   input wire logic SER_RVALID,
   input wire logic BKPT_FORCE_REQ,
   input wire logic BKPT_TAG,
   input wire logic MCU_RESET_REQ,
   input wire logic TRACE_ENABLE,
   input wire logic TRACE_ARMED
);
   // ----------------------------------------------------------------
   // decode helpers
   // ----------------------------------------------------------------
   default clocking dc @(posedge CLK_SYS); endclocking
   default disable iff (RST);
   // serial one into the forced-reset bit
   wire logic frc1 = CE && SER_CMD_VALID && SER_CMD == 3'h4 && SER_ADDR == `DBT_IDX_FRC
      && SER_WDATA[0];
   wire logic ctl_wr = CE && CPU_WR && CPU_ADDR == `DBT_IDX_CTRL;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   property p_frc_rd;
      CE && CPU_RD && CPU_ADDR == `DBT_IDX_FRC |=> CPU_RDATA == 8'h00;
   endproperty
   a_frc_rd: assert property (p_frc_rd) else $error("forced reset read not zero");
   property p_rst_req;
      frc1 |=> MCU_RESET_REQ;
   endproperty
   a_rst_req: assert property (p_rst_req) else $error("no chip reset request");
   property p_rst_src;
      MCU_RESET_REQ |-> $past(frc1);
   endproperty
   a_rst_src: assert property (p_rst_src) else $error("reset request without cause");
   property p_bk_off;
      !BKPT_ENABLE |=> !BKPT_FORCE_REQ && !BKPT_TAG;
   endproperty
   a_bk_off: assert property (p_bk_off) else $error("breakpoint while disabled");
   property p_bk_force;
      BKPT_FORCE_REQ |-> $past(BKPT_ENABLE && FORCE_TAG_SELECT && CPU_BUS_VALID);
   endproperty
   a_bk_force: assert property (p_bk_force) else $error("force request wrong");
   property p_bk_tag;
      BKPT_TAG |-> $past(BKPT_ENABLE && !FORCE_TAG_SELECT && OPCODE_FETCH);
   endproperty
   a_bk_tag: assert property (p_bk_tag) else $error("tag request wrong");
   property p_ser_rd;
      CE && SER_CMD_VALID && SER_CMD == 3'h2 |=> SER_RVALID;
   endproperty
   a_ser_rd: assert property (p_ser_rd) else $error("breakpoint read not answered");
   property p_ctl_wr;
      ctl_wr |=> TRACE_ENABLE == ($past(CPU_WDATA[7]) && !$past(SECURED));
   endproperty
   a_ctl_wr: assert property (p_ctl_wr) else $error("enable write wrong");
   property p_arm_en;
      TRACE_ARMED |-> TRACE_ENABLE;
   endproperty
   a_arm_en: assert property (p_arm_en) else $error("armed while disabled");
   property p_arm_done;
      TRACE_ARMED && CE && RUN_DONE && !ctl_wr |=> !TRACE_ARMED;
   endproperty
   a_arm_done: assert property (p_arm_done) else $error("armed after run done");
endmodule : dbt_debug_regs_sva

bind dbt_debug_regs dbt_debug_regs_sva u_sva (
   .CLK_SYS(CLK_SYS), .RST(RST), .CE(CE), .CPU_ADDR(CPU_ADDR), .CPU_RD(CPU_RD),
   .CPU_WR(CPU_WR), .CPU_WDATA(CPU_WDATA), .CPU_RDATA(CPU_RDATA), .SECURED(SECURED),
   .CPU_BUS_VALID(CPU_BUS_VALID), .OPCODE_FETCH(OPCODE_FETCH), .RUN_DONE(RUN_DONE),
   .BKPT_ENABLE(BKPT_ENABLE), .FORCE_TAG_SELECT(FORCE_TAG_SELECT), .SER_CMD(SER_CMD),
   .SER_CMD_VALID(SER_CMD_VALID), .SER_ADDR(SER_ADDR), .SER_WDATA(SER_WDATA),
   .SER_RVALID(SER_RVALID), .BKPT_FORCE_REQ(BKPT_FORCE_REQ), .BKPT_TAG(BKPT_TAG),
   .MCU_RESET_REQ(MCU_RESET_REQ), .TRACE_ENABLE(TRACE_ENABLE), .TRACE_ARMED(TRACE_ARMED)
);

// ---- dv/dbt_host_model.sv ----
// Purpose: external debug host issuing serial background commands
// Assumes: commands launched at a falling edge, taken at the next rising edge
// Notes: idle fields are inverted so a stale value never passes for a live one
`timescale 1ns/1ps
module dbt_host_model (
   input wire logic clk,
   output logic cmd_valid,
   output logic [2:0] cmd,
   output logic [3:0] addr,
   output logic [15:0] wdata,
   input wire logic [15:0] rdata,
   input wire logic rvalid
);
   int slow = 0; // idle cycles before a command, models a slow host
   // quiet bus at time zero
   initial begin
      cmd_valid = 1'b0;
      cmd = 3'h0;
      addr = 4'h0;
      wdata = 16'h0000;
   end
   // one command for one cycle, then release
   task automatic send(input logic [2:0] c, input logic [3:0] a, input logic [15:0] d);
      repeat (slow) @(negedge clk);
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd = c;
      addr = a;
      wdata = d;
      @(negedge clk);
      cmd_valid = 1'b0;
      cmd = ~cmd;
      addr = ~addr;
      wdata = ~wdata;
   endtask : send
   task automatic wr_bkpt(input logic [15:0] d);
      send(dbt_pkg::SC_WRITE_BREAKPOINT_CMD, 4'h0, d);
   endtask : wr_bkpt
   // answer one cycle after the command
   task automatic rd_bkpt(output logic [15:0] d);
      send(dbt_pkg::SC_READ_BREAKPOINT_CMD, 4'h0, 16'h0000);
      d = rvalid ? rdata : 16'hxxxx;
   endtask : rd_bkpt
   // forced reset only by write byte
   task automatic wr_byte(input logic [3:0] a, input logic b);
      send(dbt_pkg::SC_WRITE_BYTE, a, {15'h0000, b});
   endtask : wr_byte
endmodule : dbt_host_model

// ---- dv/dbt_debug_regs_bench.sv ----
// Purpose: self-checking bench of the debug breakpoint and trace registers
// Assumes: inputs change at the falling edge, CE held high except for one dropped write in t_regs
// Notes: expected values come from the register map and the stimulus
`timescale 1ns/1ps
`include "dbt_cfg.svh"
module dbt_debug_regs_bench;
   logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, bv = 1'b0, of = 1'b0;
   logic sec = 1'b0, done = 1'b0, cv = 1'b0, evo = 1'b0, bke = 1'b0, force_tag_select = 1'b0, ce = 1'b1;
   logic [3:0] a = 4'h0;
   logic [7:0] wd = 8'h00;
   logic [15:0] ba = 16'h0000, cd = 16'h0000, w;
   logic [7:0] rdat;
   logic sv, srv, frq, tg, mrq, ma, mb, ten, tarm;
   logic [2:0] sc;
   logic [5:0] cf;
   logic [3:0] sa;
   logic [15:0] sw, srd;
   int err_total = 0;
   int n_compared = 0;
   always #4 clk = ~clk;

   dbt_debug_regs #(.FIFO_DEPTH(8)) dut (
      .CLK_SYS(clk), .RST(rst), .CE(ce), .CPU_ADDR(a), .CPU_RD(rd), .CPU_WR(wr),
      .CPU_WDATA(wd), .CPU_RDATA(rdat), .CPU_BUS_ADDR(ba), .CPU_BUS_VALID(bv),
      .OPCODE_FETCH(of), .SECURED(sec), .RUN_DONE(done), .TRACE_CAP_VALID(cv),
      .TRACE_CAP_DATA(cd), .EVENT_ONLY(evo), .BKPT_ENABLE(bke), .FORCE_TAG_SELECT(force_tag_select),
      .SER_CMD_VALID(sv), .SER_CMD(sc), .SER_ADDR(sa), .SER_WDATA(sw), .SER_RDATA(srd),
      .SER_RVALID(srv), .BKPT_FORCE_REQ(frq), .BKPT_TAG(tg), .MCU_RESET_REQ(mrq),
      .CMP_A_MATCH(ma), .CMP_B_MATCH(mb), .TRACE_ENABLE(ten), .TRACE_ARMED(tarm),
      .TRACE_TAG_MODE(cf[5]), .TRACE_BREAK_EN(cf[4]), .TRACE_RW_SEL(cf[3:0])
   );
   dbt_host_model host (
      .clk(clk), .cmd_valid(sv), .cmd(sc), .addr(sa), .wdata(sw), .rdata(srd), .rvalid(srv)
   );

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic chkb(input logic g, input logic e);
      chk({15'h0000, g}, {15'h0000, e});
   endtask : chkb
   task automatic cw(input logic [3:0] i, input logic [7:0] d);
      @(negedge clk);
      wr = 1'b1;
      a = i;
      wd = d;
      @(negedge clk);
      wr = 1'b0;
   endtask : cw
   // read is registered, so the data is there one falling edge later
   task automatic cr(input logic [3:0] i, input logic [7:0] e);
      @(negedge clk);
      rd = 1'b1;
      a = i;
      @(negedge clk);
      rd = 1'b0;
      chk({8'h00, rdat}, {8'h00, e});
   endtask : cr
   task automatic bus(input logic [15:0] ad, input logic f);
      @(negedge clk);
      ba = ad;
      bv = 1'b1;
      of = f;
      @(negedge clk);
      bv = 1'b0;
      of = 1'b0;
      ba = ~ba;
   endtask : bus
   task automatic cap(input logic [15:0] d);
      @(negedge clk);
      cv = 1'b1;
      cd = d;
      @(negedge clk);
      cv = 1'b0;
      cd = ~cd;
   endtask : cap

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_regs;
      for (int i = 0; i < 4; i++) cr(i[3:0], 8'h00);
      ce = 1'b0;
      cw(4'h0, 8'h77);
      ce = 1'b1;
      cr(4'h0, 8'h00);
      cw(`DBT_IDX_FRC, 8'h01);
      cr(`DBT_IDX_FRC, 8'h00);
      cr(4'hf, 8'h00);
      cw(4'h0, 8'ha5);
      cw(4'h1, 8'h5a);
      cw(4'h2, 8'hc3);
      cw(4'h3, 8'h3c);
      cr(4'h1, 8'h5a);
      cr(4'h2, 8'hc3);
      bus(16'ha55a, 1'b0);
      chkb(ma, 1'b1);
      chkb(mb, 1'b0);
      bus(16'hc33c, 1'b0);
      chkb(mb, 1'b1);
   endtask : t_regs
   task automatic t_bkpt;
      host.wr_bkpt(16'h1234);
      host.slow = 2;
      host.rd_bkpt(w);
      chk(w, 16'h1234);
      host.slow = 0;
      // force, tag, then disabled
      for (int i = 0; i < 3; i++) begin
         bke = (i != 2);
         force_tag_select = (i == 0);
         bus(16'h1234, 1'b1);
         chkb(frq, i == 0);
         chkb(tg, i == 1);
      end
      bke = 1'b1;
      bus(16'h1235, 1'b1);
      chkb(tg, 1'b0);
      bke = 1'b0;
   endtask : t_bkpt
   task automatic t_ctrl;
      cw(`DBT_IDX_CTRL, 8'h3f);
      cr(`DBT_IDX_CTRL, 8'h3f);
      chk({10'h000, cf}, 16'h003f);
      cw(`DBT_IDX_CTRL, 8'h40);
      chkb(tarm, 1'b0);
      sec = 1'b1;
      cw(`DBT_IDX_CTRL, 8'h80);
      cr(`DBT_IDX_CTRL, 8'h00);
      sec = 1'b0;
   endtask : t_ctrl
   task automatic t_trace;
      cw(`DBT_IDX_CTRL, 8'hc0);
      chkb(tarm, 1'b1);
      cw(4'h0, 8'hff);
      cr(4'h0, 8'ha5);
      cr(`DBT_IDX_STAT, 8'h80);
      for (int i = 0; i < 8; i++) cap({8'h20 + i[7:0], 8'h40 + i[7:0]});
      cr(`DBT_IDX_FL, 8'h40);
      cr(`DBT_IDX_FL, 8'h40);
      @(negedge clk);
      done = 1'b1;
      @(negedge clk);
      done = 1'b0;
      chkb(tarm, 1'b0);
      // unarmed drain, each low read pushes the last fetch
      for (int i = 0; i < 8; i++) begin
         bus(16'h8a10 + 16'(i), 1'b1);
         cr(`DBT_IDX_FH, 8'h20 + i[7:0]);
         cr(`DBT_IDX_FH, 8'h20 + i[7:0]);
         cr(`DBT_IDX_FL, 8'h40 + i[7:0]);
      end
      cr(`DBT_IDX_FH, 8'h8a);
      cr(`DBT_IDX_FL, 8'h10);
   endtask : t_trace
   task automatic t_event;
      evo = 1'b1;
      cw(`DBT_IDX_CTRL, 8'hc0);
      for (int i = 0; i < 8; i++) cap(16'hff30 + 16'(i));
      cw(`DBT_IDX_CTRL, 8'h00);
      chkb(tarm, 1'b0);
      evo = 1'b0;
      cw(`DBT_IDX_FH, 8'hff);
      cr(`DBT_IDX_FH, 8'h00);
      cr(`DBT_IDX_FL, 8'h30);
      cw(`DBT_IDX_FL, 8'hff);
      cr(`DBT_IDX_FL, 8'h31);
   endtask : t_event
   task automatic t_frc;
      host.wr_byte(`DBT_IDX_FRC, 1'b0);
      chkb(mrq, 1'b0);
      host.wr_byte(`DBT_IDX_CTRL, 1'b1);
      chkb(mrq, 1'b0);
      host.wr_byte(`DBT_IDX_FRC, 1'b1);
      chkb(mrq, 1'b1);
      @(negedge clk);
      rst = 1'b1;
      repeat (5) @(negedge clk);
      rst = 1'b0;
      cr(4'h0, 8'h00);
   endtask : t_frc

   // ----------------------------------------------------------------
   // run control
   // ----------------------------------------------------------------
   task automatic complete_run;
      if (err_total == 0 && n_compared > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : complete_run
   initial begin
      repeat (5) @(negedge clk);
      rst = 1'b0;
      t_regs;
      t_bkpt;
      t_ctrl;
      t_trace;
      t_event;
      t_frc;
      complete_run;
   end
   // watchdog, far beyond the few hundred cycles the tests take
   initial begin
      repeat (20000) @(posedge clk);
      err_total++;
      complete_run;
   end
endmodule : dbt_debug_regs_bench
